// file: hdl/tcf_arm.sv
`timescale 1ns/1ps
module tcf_arm (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // events
  input wire logic stat_rd,
  input wire logic flag,
  input wire logic cmp_wr,
  // result
  output logic armed
);
  typedef struct packed {
    logic armed;
  } tcf_arm_st_t;
  tcf_arm_st_t s_q, s_d;
  always_comb begin
    s_d = s_q;
    // a status read with the flag up arms the clear; with it down disarms
    if (stat_rd) begin
      s_d.armed = flag; // RULE_03
    end else if (cmp_wr) begin
      s_d.armed = 1'b0;
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign armed = s_q.armed;
endmodule : tcf_arm

// file: hdl/tcf_timer.sv
`timescale 1ns/1ps
// Contract
// RULE_01 - flag sets when counter equals compare
// RULE_02 - clear needs flag-seen read, then compare write
// RULE_03 - read seeing zero never arms clear
// RULE_04 - match during clearing write keeps flag
// RULE_05 - software avoids matches between read, write
module tcf_timer #(
  parameter int CNT_W = tcf_pkg::CNT_W
) (
  // clock and reset
  input wire logic CLK,
  input wire logic ARST_N,
  // status register access
  input wire logic STAT_RD,
  // compare register access
  input wire logic CMP_WR,
  input wire logic [CNT_W-1:0] CMP_WDATA,
  // state
  output logic [CNT_W-1:0] FREE_RUNNING_COUNTER,
  output logic [CNT_W-1:0] COMPARE_VALUE_REG,
  output logic COMPARE_MATCH_FLAG,
  output logic [7:0] TIMER_CTRL_STATUS_REG,
  output logic MATCH_PULSE
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] cmp;
    logic flag;
    logic [7:0] stat;
    logic pulse;
  } tcf_timer_st_t;

  tcf_timer_st_t s_q;
  tcf_timer_st_t s_d;

  // clear armed by a status read that saw the flag up
  logic armed;

  // ripple increment of the free-running count
  logic [CNT_W-1:0] inc_carry;
  logic [CNT_W-1:0] cnt_inc;

  // per-bit equality of count and compare word
  logic [CNT_W-1:0] bit_eq;
  logic match;

  // compare word after this cycle's write
  logic [CNT_W-1:0] cmp_next;

  // flag requests of this cycle
  logic set_req;
  logic clr_req;
  logic clr_ok;

  tcf_arm u_arm (
    .clk(CLK),
    .arst_n(ARST_N),
    .stat_rd(STAT_RD),
    .flag(s_q.flag),
    .cmp_wr(CMP_WR),
    .armed(armed)
  );

  assign inc_carry[0] = 1'b1;

  // per-bit slice: increment, equality, compare load
  for (genvar b = 0; b < CNT_W; b++) begin : g_bit
    // count wraps at full scale
    assign cnt_inc[b] = s_q.cnt[b] ^ inc_carry[b];
    if (b < CNT_W - 1) begin : g_carry
      assign inc_carry[b + 1] = s_q.cnt[b] & inc_carry[b];
    end
    // registered count against registered compare word
    assign bit_eq[b] = ~(s_q.cnt[b] ^ s_q.cmp[b]);
    // compare word is taken whole in one strobe
    assign cmp_next[b] = CMP_WR ? CMP_WDATA[b] : s_q.cmp[b];
  end

  // a word written this cycle takes part from the next one
  assign match = &bit_eq; // RULE_01
  assign set_req = match; // RULE_01

  // a write overlapping a status read never clears
  assign clr_req = CMP_WR && !STAT_RD;
  // only a read that saw the flag up arms the clear
  assign clr_ok = clr_req && armed; // RULE_02 RULE_03

  always_comb begin
    s_d = s_q;
    s_d.cnt = cnt_inc;
    s_d.cmp = cmp_next;
    // set wins over clear in the same cycle
    case ({set_req, clr_ok})
      2'b11: begin
        s_d.flag = 1'b1; // RULE_04
      end
      2'b10: begin
        s_d.flag = 1'b1; // RULE_01
      end
      2'b01: begin
        s_d.flag = 1'b0; // RULE_02
      end
      default: begin
        s_d.flag = s_q.flag;
      end
    endcase
    s_d.stat = tcf_pkg::STAT_RST;
    s_d.stat[tcf_pkg::FLAG_BIT] = s_d.flag;
    s_d.pulse = match; // RULE_01
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      s_q.cnt <= CNT_W'(tcf_pkg::CNT_RST);
      s_q.cmp <= CNT_W'(tcf_pkg::CMP_RST);
      s_q.flag <= tcf_pkg::FLAG_RST;
      s_q.stat <= tcf_pkg::STAT_RST;
      s_q.pulse <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign FREE_RUNNING_COUNTER = s_q.cnt;
  assign COMPARE_VALUE_REG = s_q.cmp;
  assign COMPARE_MATCH_FLAG = s_q.flag;
  assign TIMER_CTRL_STATUS_REG = s_q.stat;
  assign MATCH_PULSE = s_q.pulse;
endmodule : tcf_timer

// file: pkg/tcf_pkg.sv
package tcf_pkg;
  localparam int CNT_W = 16;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] CMP_RST = 16'hFFFF;
  localparam logic FLAG_RST = 1'b0;
  localparam int FLAG_BIT = 6;
  localparam logic [7:0] STAT_RST = 8'h00;
endpackage : tcf_pkg

// file: sim/tb.sv
`timescale 1ns/1ps
module tb;
  logic CLK = 0, ARST_N = 0, STAT_RD = 0, CMP_WR = 0, COMPARE_MATCH_FLAG, MATCH_PULSE;
  logic [15:0] CMP_WDATA = 16'h0000, FREE_RUNNING_COUNTER, COMPARE_VALUE_REG, v, q[$];
  logic [7:0] TIMER_CTRL_STATUS_REG;
  logic [31:0] s = 32'h074096F5;
  int n_errors = 0, comparisons = 0;
  always #12.5 CLK = ~CLK;
  tcf_timer dut (
    .CLK(CLK),
    .ARST_N(ARST_N),
    .STAT_RD(STAT_RD),
    .CMP_WR(CMP_WR),
    .CMP_WDATA(CMP_WDATA),
    .FREE_RUNNING_COUNTER(FREE_RUNNING_COUNTER),
    .COMPARE_VALUE_REG(COMPARE_VALUE_REG),
    .COMPARE_MATCH_FLAG(COMPARE_MATCH_FLAG),
    .TIMER_CTRL_STATUS_REG(TIMER_CTRL_STATUS_REG),
    .MATCH_PULSE(MATCH_PULSE)
  );
  function logic [31:0] nx(logic [31:0] x); return {x[30:0], ^(x & 32'h80200003)}; endfunction : nx
  task check(logic [15:0] a, e);
    comparisons++;
    if (a !== e) begin
      n_errors++;
      $display("mismatch %0t %h %h", $time, a, e);
    end
  endtask : check
  task test_done;
    $display("%0d mismatches, %0d comparisons", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done
  task wr(logic [15:0] d);
    {CMP_WR, CMP_WDATA} <= {1'b1, d};
    @(posedge CLK) CMP_WR <= 1'b0;
  endtask : wr
  always @(negedge CLK) if (MATCH_PULSE === 1'b1 && q.size() > 0) check(FREE_RUNNING_COUNTER, q.pop_front());
  initial begin
    repeat (12) @(posedge CLK);
    ARST_N <= 1'b1;
    // 0..3 clean clears, 4 late set, 5 match in clearing write
    for (int k = 0; k < 6; k++) begin
      @(posedge CLK) s = nx(s);
      v = FREE_RUNNING_COUNTER + (k < 4 ? 16'h0004 + s[7:0] : 16'h0003);
      wr(v);
      q.push_back(v + 16'h0001);
      for (int i = 0; k < 4 && COMPARE_MATCH_FLAG !== 1'b1; i++)
        if (i > 300) begin n_errors++; test_done; end else @(posedge CLK);
      STAT_RD <= 1'b1;
      @(posedge CLK) STAT_RD <= 1'b0;
      if (k == 4) @(posedge CLK);
      v = FREE_RUNNING_COUNTER + 16'h0100;
      wr(v);
      @(negedge CLK) check(16'(COMPARE_MATCH_FLAG), 16'(k > 3));
      check(16'(TIMER_CTRL_STATUS_REG), 16'(k > 3) << tcf_pkg::FLAG_BIT);
      check(COMPARE_VALUE_REG, v);
      $display("test %0d done", k);
    end
    @(posedge CLK);
    check(16'(q.size()), 16'h0000);
    test_done;
  end
endmodule : tb

// file: sim/tcf_timer_assertions.sv
`timescale 1ns/1ps
module tcf_chk #(
  parameter int CNT_W = tcf_pkg::CNT_W
) (
  // clock and reset
  input wire logic CLK,
  input wire logic ARST_N,
  // strobes
  input wire logic STAT_RD,
  input wire logic CMP_WR,
  // watched state
  input wire logic COMPARE_MATCH_FLAG,
  input wire logic MATCH_PULSE,
  input wire logic [7:0] TIMER_CTRL_STATUS_REG,
  input wire logic [CNT_W-1:0] FREE_RUNNING_COUNTER,
  input wire logic [CNT_W-1:0] COMPARE_VALUE_REG
);
  wire m = FREE_RUNNING_COUNTER == COMPARE_VALUE_REG, f = COMPARE_MATCH_FLAG, w = CMP_WR & !STAT_RD;
  default clocking @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  sequence rd_seen; f & STAT_RD; endsequence
  sequence rd_missed; !f & STAT_RD; endsequence
  flag_set_a: assert property (m |=> f) else $error("no set");
  flag_clr_a: assert property (rd_seen ##1 w & !m |=> !f) else $error("no clear");
  late_set_a: assert property (rd_missed ##1 m & !STAT_RD ##1 w |=> f) else $error("set lost");
  race_keep_a: assert property (rd_seen ##1 w & m |=> f) else $error("set lost");
  pulse_track_a: assert property (MATCH_PULSE == $past(m)) else $error("pulse off");
  stat_mirror_a: assert property (TIMER_CTRL_STATUS_REG == (8'(f) << tcf_pkg::FLAG_BIT)) else $error("stat off");
endmodule : tcf_chk
bind tcf_timer tcf_chk #(.CNT_W(CNT_W)) u_chk (
  .CLK(CLK),
  .ARST_N(ARST_N),
  .STAT_RD(STAT_RD),
  .CMP_WR(CMP_WR),
  .COMPARE_MATCH_FLAG(COMPARE_MATCH_FLAG),
  .MATCH_PULSE(MATCH_PULSE),
  .TIMER_CTRL_STATUS_REG(TIMER_CTRL_STATUS_REG),
  .FREE_RUNNING_COUNTER(FREE_RUNNING_COUNTER),
  .COMPARE_VALUE_REG(COMPARE_VALUE_REG)
);
